// [self_test_defs.vh]
// constants for the self test and probe multiplexer
`ifndef SELF_TEST_DEFS_VH
`define SELF_TEST_DEFS_VH
`define ARM_CODE 8'h09
`define SIG_BYTES 7'h40
`define GROUP_RX 5'h07
`define GROUP_OSC 5'h0D
`define SEL_TRI 4'h0
`define SEL_DAC_REG 4'h1
`define SEL_CORR 4'h2
`define SEL_MINLEV 4'h4
`define SEL_ADC_I 4'h5
`define SEL_ADC_Q 4'h6
`define SEL_HIGH 4'hA
`define SEL_LOW 4'hB
`define SEL_TX_ACT 4'hC
`define SEL_RX_ACT 4'hD
`define SEL_SUBC 4'hE
`define SEL_BUS_BIT 4'hF
`define SIG_SEED 8'hA5
`define DAC_MAX 6'h3F
`endif

// [aux_pin_mux.v]
// one auxiliary probe pin source selector
`timescale 1ns/1ps
`default_nettype none
`include "self_test_defs.vh"
module aux_pin_mux (
  input wire mclk_in,
  input wire reset_n_in,
  input wire [3:0] source_select_in,
  input wire [5:0] probe_dac_in,
  input wire [5:0] correlator_level_in,
  input wire [5:0] minimum_level_probe_in,
  input wire [5:0] adc_i_in,
  input wire [5:0] adc_q_in,
  input wire transmit_active_flag_in,
  input wire receive_active_flag_in,
  input wire subcarrier_in,
  input wire probe_bus_bit_in,
  output reg [5:0] dac_level_out,
  output reg dac_en_out,
  output reg pin_out,
  output reg pin_oe_out
);
  reg [5:0] lvl_nxt;
  reg den_nxt;
  reg pin_nxt;
  reg oe_nxt;
  always @* begin
    lvl_nxt = 6'h00;
    den_nxt = 1'b0;
    pin_nxt = 1'b0;
    oe_nxt = 1'b0;
    case (source_select_in)
      `SEL_DAC_REG: begin lvl_nxt = probe_dac_in; den_nxt = 1'b1; end
      `SEL_CORR: begin lvl_nxt = correlator_level_in; den_nxt = 1'b1; end
      `SEL_MINLEV: begin lvl_nxt = minimum_level_probe_in; den_nxt = 1'b1; end
      `SEL_ADC_I: begin lvl_nxt = adc_i_in; den_nxt = 1'b1; end
      `SEL_ADC_Q: begin lvl_nxt = adc_q_in; den_nxt = 1'b1; end
      `SEL_HIGH: begin pin_nxt = 1'b1; oe_nxt = 1'b1; end
      `SEL_LOW: begin pin_nxt = 1'b0; oe_nxt = 1'b1; end
      `SEL_TX_ACT: begin pin_nxt = transmit_active_flag_in; oe_nxt = 1'b1; end
      `SEL_RX_ACT: begin pin_nxt = receive_active_flag_in; oe_nxt = 1'b1; end
      `SEL_SUBC: begin pin_nxt = subcarrier_in; oe_nxt = 1'b1; end
      `SEL_BUS_BIT: begin pin_nxt = probe_bus_bit_in; oe_nxt = 1'b1; end
      // 0000 and reserved codes leave the pin floating
      default: begin oe_nxt = 1'b0; end
    endcase
  end
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dac_level_out <= 6'h00;
      dac_en_out <= 1'b0;
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
    end else begin
      dac_level_out <= lvl_nxt;
      dac_en_out <= den_nxt;
      pin_out <= pin_nxt;
      pin_oe_out <= oe_nxt;
    end
  end
endmodule // aux_pin_mux
`default_nettype wire

// [self_test_and_probe_mux.v]
// self test signature generator and probe bus routing
`timescale 1ns/1ps
`default_nettype none
`include "self_test_defs.vh"
module self_test_and_probe_mux (
  input wire mclk_in,
  input wire reset_n_in,
  input wire soft_reset_in,
  input wire [7:0] self_test_control_in,
  input wire self_test_control_we_in,
  input wire crc_calc_command_in,
  input wire fifo_ready_in,
  input wire [4:0] probe_group_select_in,
  input wire [2:0] probe_line_select_in,
  input wire [7:0] aux_pin_control_in,
  input wire [7:0] probe_dac_value_one_in,
  input wire [7:0] probe_dac_value_two_in,
  input wire rx_data_in,
  input wire rx_coll_in,
  input wire rx_valid_in,
  input wire rx_stop_in,
  input wire receiver_reset_flag_in,
  input wire lowest_rate_in,
  input wire osc_stable_in,
  input wire osc_raw_in,
  input wire [5:0] normal_lines_in,
  input wire [5:0] correlator_level_in,
  input wire [5:0] minimum_level_probe_in,
  input wire [5:0] adc_i_in,
  input wire [5:0] adc_q_in,
  input wire transmit_active_flag_in,
  input wire receive_active_flag_in,
  input wire subcarrier_in,
  output reg self_test_armed_out,
  output reg self_test_busy_out,
  output reg self_test_done_out,
  output reg crc_run_out,
  output reg [7:0] fifo_wdata_out,
  output reg fifo_wr_out,
  output reg [5:0] probe_lines_out,
  output reg probe_override_out,
  output reg osc_div8_out,
  output wire [5:0] aux_one_dac_out,
  output wire aux_one_dac_en_out,
  output wire analog_probe_pin_one_out,
  output wire analog_probe_pin_one_oe_out,
  output wire [5:0] aux_two_dac_out,
  output wire aux_two_dac_en_out,
  output wire analog_probe_pin_two_out,
  output wire analog_probe_pin_two_oe_out
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_DONE = 2'd2;
  reg [1:0] state_r;
  reg [6:0] count_r;
  reg [7:0] lfsr_r;
  reg [2:0] div_r;
  reg [5:0] lines_nxt;
  reg override_nxt;
  reg bus_bit_nxt;
  wire [5:0] probe_dac_one;
  wire [5:0] probe_dac_two;
  wire [3:0] aux_one_source_select;
  wire [3:0] aux_two_source_select;
  wire [5:0] probe_bus;
  wire coll_gated;
  wire [7:0] lfsr_nxt;
  // truncate DAC registers to 6 bits, bits 7:6 of values above 3Fh are dropped
  assign probe_dac_one = probe_dac_value_one_in[5:0] & `DAC_MAX;
  assign probe_dac_two = probe_dac_value_two_in[5:0] & `DAC_MAX;
  assign aux_one_source_select = aux_pin_control_in[7:4];
  assign aux_two_source_select = aux_pin_control_in[3:0];
  // collision only trusted at the lowest rate and while valid
  assign coll_gated = rx_coll_in & lowest_rate_in & rx_valid_in;
  assign lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
  assign probe_bus = lines_nxt;
  // line n sits at index n-1; select 0 and 7 name no line, so the bit stays low
  always @* begin
    bus_bit_nxt = 1'b0;
    case (probe_line_select_in)
      3'h1: bus_bit_nxt = probe_bus[0];
      3'h2: bus_bit_nxt = probe_bus[1];
      3'h3: bus_bit_nxt = probe_bus[2];
      3'h4: bus_bit_nxt = probe_bus[3];
      3'h5: bus_bit_nxt = probe_bus[4];
      3'h6: bus_bit_nxt = probe_bus[5];
      default: bus_bit_nxt = 1'b0;
    endcase
  end
  always @* begin
    lines_nxt = normal_lines_in;
    override_nxt = 1'b0;
    case (probe_group_select_in)
      `GROUP_RX: begin
        // index 5 is line six, index 0 is line one (reserved, low)
        lines_nxt = {rx_data_in & rx_valid_in, coll_gated, rx_valid_in,
                     rx_stop_in, receiver_reset_flag_in, 1'b0};
        override_nxt = 1'b1;
      end
      `GROUP_OSC: begin
        lines_nxt = {osc_stable_in, div_r[2], 2'b00, osc_raw_in, 1'b0};
        override_nxt = 1'b1;
      end
      default: begin
        lines_nxt = normal_lines_in;
        override_nxt = 1'b0;
      end
    endcase
  end
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_r <= 3'h0;
      osc_div8_out <= 1'b0;
      probe_lines_out <= 6'h00;
      probe_override_out <= 1'b0;
    end else begin
      div_r <= div_r + 3'h1;
      osc_div8_out <= div_r[2];
      probe_lines_out <= lines_nxt;
      probe_override_out <= override_nxt;
    end
  end
  // self test sequencer; soft reset returns it to the seed so runs repeat
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      count_r <= 7'h00;
      lfsr_r <= `SIG_SEED;
      self_test_armed_out <= 1'b0;
      self_test_busy_out <= 1'b0;
      self_test_done_out <= 1'b0;
      crc_run_out <= 1'b0;
      fifo_wdata_out <= 8'h00;
      fifo_wr_out <= 1'b0;
    end else if (soft_reset_in) begin
      state_r <= ST_IDLE;
      count_r <= 7'h00;
      lfsr_r <= `SIG_SEED;
      self_test_armed_out <= 1'b0;
      self_test_busy_out <= 1'b0;
      self_test_done_out <= 1'b0;
      crc_run_out <= 1'b0;
      fifo_wr_out <= 1'b0;
    end else begin
      fifo_wr_out <= 1'b0;
      crc_run_out <= 1'b0;
      if (self_test_control_we_in) begin
        self_test_armed_out <= (self_test_control_in == `ARM_CODE);
      end
      case (state_r)
        ST_IDLE: begin
          if (crc_calc_command_in && self_test_armed_out) begin
            state_r <= ST_RUN;
            count_r <= 7'h00;
            lfsr_r <= `SIG_SEED;
            self_test_busy_out <= 1'b1;
            self_test_done_out <= 1'b0;
          end else if (crc_calc_command_in) begin
            crc_run_out <= 1'b1;
          end
        end
        ST_RUN: begin
          // fifo back-pressure stalls generation, no byte is dropped
          if (fifo_ready_in) begin
            fifo_wdata_out <= lfsr_r;
            fifo_wr_out <= 1'b1;
            lfsr_r <= lfsr_nxt;
            count_r <= count_r + 7'h01;
            if (count_r == (`SIG_BYTES - 7'h01)) begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          self_test_busy_out <= 1'b0;
          self_test_done_out <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  aux_pin_mux u_aux_one (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .source_select_in(aux_one_source_select),
    .probe_dac_in(probe_dac_one),
    .correlator_level_in(correlator_level_in),
    .minimum_level_probe_in(minimum_level_probe_in),
    .adc_i_in(adc_i_in),
    .adc_q_in(adc_q_in),
    .transmit_active_flag_in(transmit_active_flag_in),
    .receive_active_flag_in(receive_active_flag_in),
    .subcarrier_in(subcarrier_in),
    .probe_bus_bit_in(bus_bit_nxt),
    .dac_level_out(aux_one_dac_out),
    .dac_en_out(aux_one_dac_en_out),
    .pin_out(analog_probe_pin_one_out),
    .pin_oe_out(analog_probe_pin_one_oe_out)
  );
  aux_pin_mux u_aux_two (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .source_select_in(aux_two_source_select),
    .probe_dac_in(probe_dac_two),
    .correlator_level_in(correlator_level_in),
    .minimum_level_probe_in(minimum_level_probe_in),
    .adc_i_in(adc_i_in),
    .adc_q_in(adc_q_in),
    .transmit_active_flag_in(transmit_active_flag_in),
    .receive_active_flag_in(receive_active_flag_in),
    .subcarrier_in(subcarrier_in),
    .probe_bus_bit_in(bus_bit_nxt),
    .dac_level_out(aux_two_dac_out),
    .dac_en_out(aux_two_dac_en_out),
    .pin_out(analog_probe_pin_two_out),
    .pin_oe_out(analog_probe_pin_two_oe_out)
  );
endmodule // self_test_and_probe_mux
`default_nettype wire

// [self_test_props.sv]
// assertions on the self test and probe mux ports
`timescale 1ns/1ps
`default_nettype none
module self_test_props (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic soft_reset_in,
  input wire logic [7:0] self_test_control_in,
  input wire logic self_test_control_we_in,
  input wire logic crc_calc_command_in,
  input wire logic [4:0] probe_group_select_in,
  input wire logic [7:0] aux_pin_control_in,
  input wire logic self_test_armed_out,
  input wire logic self_test_busy_out,
  input wire logic self_test_done_out,
  input wire logic crc_run_out,
  input wire logic fifo_wr_out,
  input wire logic probe_override_out,
  input wire logic osc_div8_out,
  input wire logic aux_one_dac_en_out,
  input wire logic analog_probe_pin_one_out,
  input wire logic analog_probe_pin_one_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  logic [7:0] wr_cnt_r;
  wire logic [3:0] sel = aux_pin_control_in[7:4];
  wire logic grp = probe_group_select_in == 5'h07 || probe_group_select_in == 5'h0D;
  sequence idle_crc_s;
    crc_calc_command_in && !self_test_busy_out && !soft_reset_in;
  endsequence
  sequence start_s;
    idle_crc_s and self_test_armed_out;
  endsequence
  // counts bytes of one run, so a short or long signature is caught at done
  always_ff @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in) wr_cnt_r <= 8'h00;
    else if (crc_calc_command_in && !self_test_busy_out) wr_cnt_r <= 8'h00;
    else if (fifo_wr_out) wr_cnt_r <= wr_cnt_r + 8'h01;
  a_arm_code: assert property (self_test_control_we_in && self_test_control_in == 8'h09
    && !soft_reset_in |=> self_test_armed_out) else $error("arm write ignored");
  a_soft_idle: assert property (soft_reset_in |=> !self_test_armed_out && !self_test_busy_out)
    else $error("soft reset left test active");
  a_start_run: assert property (start_s |=> self_test_busy_out && !crc_run_out)
    else $error("armed crc did not start test");
  a_plain_crc: assert property (idle_crc_s and !self_test_armed_out |=> crc_run_out)
    else $error("plain crc not requested");
  a_sig_count: assert property ($rose(self_test_done_out) |-> wr_cnt_r == 8'h40)
    else $error("signature byte count wrong");
  a_div8_wave: assert property ($rose(osc_div8_out) |=> osc_div8_out [*3] ##1 !osc_div8_out)
    else $error("divided clock period wrong");
  a_aux_float: assert property (sel inside {4'h0, 4'h3, 4'h7, 4'h8, 4'h9}
    |=> !analog_probe_pin_one_oe_out && !aux_one_dac_en_out) else $error("aux not floating");
  a_aux_level: assert property (sel[3:1] == 3'b101 |=> analog_probe_pin_one_oe_out
    && analog_probe_pin_one_out == !$past(sel[0])) else $error("aux level wrong");
  a_group_on: assert property (grp |=> probe_override_out)
    else $error("probe group not routed");
  a_group_off: assert property (!grp |=> !probe_override_out)
    else $error("probe lines overridden");
endmodule // self_test_props
bind self_test_and_probe_mux self_test_props props (.*);
`default_nettype wire

// [host_model.sv]
// host side model driving the self test controls
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic mclk_in,
  output logic soft_reset_in,
  output logic [7:0] self_test_control_in,
  output logic self_test_control_we_in,
  output logic crc_calc_command_in,
  output logic fifo_ready_in
);
  logic slow;
  initial begin
    {slow, soft_reset_in, self_test_control_we_in, crc_calc_command_in} = 4'h0;
    self_test_control_in = 8'hFF;
    fifo_ready_in = 1'b1;
  end
  // slow mode drops fifo ready every other cycle to exercise back-pressure
  always @(posedge mclk_in) fifo_ready_in <= slow ? !fifo_ready_in : 1'b1;
  task automatic run(input logic [7:0] code);
    @(posedge mclk_in);
    soft_reset_in <= 1'b1;
    @(posedge mclk_in);
    // buffer clear and the zero byte go to the fifo outside this block
    soft_reset_in <= 1'b0;
    self_test_control_in <= code;
    self_test_control_we_in <= 1'b1;
    @(posedge mclk_in);
    self_test_control_we_in <= 1'b0;
    self_test_control_in <= ~code;
    crc_calc_command_in <= 1'b1;
    @(posedge mclk_in);
    crc_calc_command_in <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// [self_test_and_probe_mux_bench.sv]
// bench for the self test and probe mux
`timescale 1ns/1ps
`default_nettype none
module self_test_and_probe_mux_bench;
  logic mclk_in = 1'b0, reset_n_in = 1'b0, rx_data_in = 1'b0, rx_coll_in = 1'b0;
  logic rx_valid_in = 1'b0, rx_stop_in = 1'b0, receiver_reset_flag_in = 1'b0;
  logic lowest_rate_in = 1'b0, osc_stable_in = 1'b0, osc_raw_in = 1'b0, subcarrier_in = 1'b0;
  logic transmit_active_flag_in = 1'b0, receive_active_flag_in = 1'b0;
  logic [4:0] probe_group_select_in = 5'h00;
  logic [2:0] probe_line_select_in = 3'h6;
  logic [7:0] aux_pin_control_in = 8'h00, probe_dac_value_one_in = 8'h2A;
  logic [7:0] probe_dac_value_two_in = 8'hC5;
  logic [5:0] normal_lines_in = 6'h2D, correlator_level_in = 6'h11;
  logic [5:0] minimum_level_probe_in = 6'h22, adc_i_in = 6'h33, adc_q_in = 6'h0C;
  wire logic soft_reset_in, self_test_control_we_in, crc_calc_command_in, fifo_ready_in;
  wire logic [7:0] self_test_control_in, fifo_wdata_out;
  wire logic self_test_armed_out, self_test_busy_out, self_test_done_out, crc_run_out;
  wire logic fifo_wr_out, probe_override_out, osc_div8_out;
  wire logic aux_one_dac_en_out, analog_probe_pin_one_out, analog_probe_pin_one_oe_out;
  wire logic aux_two_dac_en_out, analog_probe_pin_two_out, analog_probe_pin_two_oe_out;
  wire logic [5:0] probe_lines_out, aux_one_dac_out, aux_two_dac_out;
  int fails = 0, check_count = 0, cycles = 0;
  logic [7:0] q[$];
  self_test_and_probe_mux dut (.*);
  host_model host (.*);
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (fifo_wr_out === 1'b1) q.push_back(fifo_wdata_out);
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic step;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask
  function automatic logic [8:0] pin(input logic e, input logic [5:0] d, input logic o, p);
    return {e, e ? d : 6'h00, o, o & p};
  endfunction
  function automatic logic [8:0] aux_exp(input logic [3:0] c, input logic [5:0] r, input logic p);
    case (c)
      4'h1: return {1'b1, r, 2'b00};
      4'h2: return {1'b1, 6'h11, 2'b00};
      4'h4: return {1'b1, 6'h22, 2'b00};
      4'h5: return {1'b1, 6'h33, 2'b00};
      4'h6: return {1'b1, 6'h0C, 2'b00};
      4'hA: return 9'h003;
      4'hB: return 9'h002;
      4'hC, 4'hE, 4'hF: return {8'h01, p};
      4'hD: return {8'h01, !p};
      default: return 9'h000;
    endcase
  endfunction
  task automatic t_probe;
    logic [5:0] v [3] = '{6'h3C, 6'h3D, 6'h37};
    foreach (v[i]) begin
      @(posedge mclk_in);
      probe_group_select_in <= 5'h07;
      {rx_data_in, rx_coll_in, rx_valid_in, rx_stop_in, receiver_reset_flag_in,
        lowest_rate_in} <= v[i];
      step;
      chk({probe_override_out, probe_lines_out}, {1'b1, v[i][5] & v[i][3],
        v[i][4] & v[i][0] & v[i][3], v[i][3:1], 1'b0});
    end
    @(posedge mclk_in);
    probe_group_select_in <= 5'h0D;
    {osc_stable_in, osc_raw_in} <= 2'b11;
    step;
    chk(probe_lines_out ^ {1'b0, osc_div8_out, 4'h0}, 6'h22);
    @(posedge mclk_in);
    probe_group_select_in <= 5'h1F;
    step;
    chk({probe_override_out, probe_lines_out}, 7'h2D);
  endtask
  task automatic t_aux;
    for (int k = 0; k < 32; k++) begin
      @(posedge mclk_in);
      probe_group_select_in <= 5'h07;
      {transmit_active_flag_in, receive_active_flag_in, subcarrier_in} <= {k[4], !k[4], k[4]};
      {rx_data_in, rx_valid_in} <= {1'b1, k[4]};
      aux_pin_control_in <= {k[3:0], 4'hF - k[3:0]};
      step;
      chk(pin(aux_one_dac_en_out, aux_one_dac_out, analog_probe_pin_one_oe_out,
        analog_probe_pin_one_out), aux_exp(k[3:0], 6'h2A, k[4]));
      chk(pin(aux_two_dac_en_out, aux_two_dac_out, analog_probe_pin_two_oe_out,
        analog_probe_pin_two_out), aux_exp(4'hF - k[3:0], 6'h05, k[4]));
    end
  endtask
  task automatic t_sig(input logic slow);
    logic [7:0] b;
    int n;
    b = 8'hA5;
    n = 0;
    host.slow = slow;
    q.delete();
    host.run(8'h09);
    #1 chk(self_test_busy_out, 1'b1);
    while (self_test_done_out !== 1'b1 && n < 1000) begin
      @(posedge mclk_in);
      n++;
    end
    #1 chk(8'(q.size()), 8'h40);
    foreach (q[i]) begin
      chk(q[i], b);
      b = {b[6:0], b[7] ^ b[5] ^ b[4] ^ b[3]};
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    t_probe;
    t_aux;
    host.run(8'h03);
    #1 chk({crc_run_out, self_test_busy_out}, 2'b10);
    t_sig(1'b0);
    t_sig(1'b1);
    finish_test;
  end
endmodule // self_test_and_probe_mux_bench
`default_nettype wire
